// file: dcar_regs.sv
/*
 * dcar_regs: source/destination start address and size registers of one DMA
 * channel, the read-only source byte index and the block completion flag.
 * Assumes a single 10 MHz clock, synchronous active-high reset, a register
 * master that never asserts read and write strobes together, and a transfer
 * engine that pulses one strobe per source byte and one per transferred byte.
 */
// Local design decisions: the strobed register port and the placing of the registers.
`timescale 1ns/100ps

module dcar_regs
   import dcar_pkg::*;
(
   input  wire logic              i_clk,
   input  wire logic              i_rst,
   input  wire logic [ADDR_W-1:0] i_addr,
   input  wire logic [DATA_W-1:0] i_wdata,
   input  wire logic              i_wr,
   input  wire logic              i_rd,
   output logic      [DATA_W-1:0] o_rdata,
   input  wire logic              i_src_step,
   input  wire logic              i_xfer_byte,
   input  wire logic              i_pattern_mode,
   input  wire logic              i_pattern_det,
   input  wire logic              i_done_clr,
   output logic      [DATA_W-1:0] o_src_start_addr,
   output logic      [DATA_W-1:0] o_dst_start_addr,
   output logic      [CNT_W-1:0]  o_src_byte_count,
   output logic      [CNT_W-1:0]  o_dst_byte_count,
   output logic      [CNT_W-1:0]  o_src_byte_index,
   output logic                   o_block_done_flag
);

   logic [DATA_W-1:0] src_start_addr_r;
   logic [DATA_W-1:0] src_start_addr_nxt;
   logic [DATA_W-1:0] dst_start_addr_r;
   logic [DATA_W-1:0] dst_start_addr_nxt;
   logic [CNT_W-1:0]  src_byte_count_r;
   logic [CNT_W-1:0]  src_byte_count_nxt;
   logic [CNT_W-1:0]  dst_byte_count_r;
   logic [CNT_W-1:0]  dst_byte_count_nxt;
   logic [CNT_W-1:0]  src_byte_index_r;
   logic [CNT_W-1:0]  src_byte_index_nxt;
   logic [CNT_W-1:0]  xfer_cnt_r;
   logic [CNT_W-1:0]  xfer_cnt_nxt;
   logic              block_done_flag_r;
   logic              block_done_flag_nxt;
   logic [DATA_W-1:0] rdata_r;
   logic [DATA_W-1:0] rdata_nxt;
   logic [CNT_W-1:0]  max_count;
   logic              block_hit;
   logic              pattern_hit;

   // register writes
   always_comb
   begin
      src_start_addr_nxt = src_start_addr_r;
      dst_start_addr_nxt = dst_start_addr_r;
      src_byte_count_nxt = src_byte_count_r;
      dst_byte_count_nxt = dst_byte_count_r;
      if (i_wr)
      begin
         case (i_addr)
            OFS_SRC_START: src_start_addr_nxt = i_wdata;
            OFS_DST_START: dst_start_addr_nxt = i_wdata;
            OFS_SRC_SIZE:  src_byte_count_nxt = i_wdata[CNT_MSB:CNT_LSB];
            OFS_DST_SIZE:  dst_byte_count_nxt = i_wdata[CNT_MSB:CNT_LSB];
            default:       src_start_addr_nxt = src_start_addr_r;
         endcase
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         src_start_addr_r <= RST_SRC_START;
         dst_start_addr_r <= RST_DST_START;
         src_byte_count_r <= RST_SRC_SIZE;
         dst_byte_count_r <= RST_DST_SIZE;
      end
      else
      begin
         src_start_addr_r <= src_start_addr_nxt;
         dst_start_addr_r <= dst_start_addr_nxt;
         src_byte_count_r <= src_byte_count_nxt;
         dst_byte_count_r <= dst_byte_count_nxt;
      end
   end

   // completion at the larger of the two counts
   always_comb
   begin
      max_count   = (src_byte_count_r > dst_byte_count_r) ? src_byte_count_r
                                                          : dst_byte_count_r;
      block_hit   = i_xfer_byte && (max_count != RST_XFER_CNT)
                    && ((xfer_cnt_r + CNT_ONE) == max_count);
      pattern_hit = i_pattern_mode && i_pattern_det;
   end

   // byte index, transfer count and done flag
   always_comb
   begin
      src_byte_index_nxt  = src_byte_index_r;
      xfer_cnt_nxt        = xfer_cnt_r;
      block_done_flag_nxt = block_done_flag_r;
      if (block_hit || pattern_hit)
      begin
         src_byte_index_nxt = RST_SRC_PTR;
         xfer_cnt_nxt       = RST_XFER_CNT;
      end
      else
      begin
         if (i_src_step)
         begin
            src_byte_index_nxt = src_byte_index_r + CNT_ONE;
         end
         if (i_xfer_byte)
         begin
            xfer_cnt_nxt = xfer_cnt_r + CNT_ONE;
         end
      end
      // set wins over a clear in the same cycle
      if (i_done_clr)
      begin
         block_done_flag_nxt = 1'b0;
      end
      if (block_hit || pattern_hit)
      begin
         block_done_flag_nxt = 1'b1;
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         src_byte_index_r  <= RST_SRC_PTR;
         xfer_cnt_r        <= RST_XFER_CNT;
         block_done_flag_r <= 1'b0;
      end
      else
      begin
         src_byte_index_r  <= src_byte_index_nxt;
         xfer_cnt_r        <= xfer_cnt_nxt;
         block_done_flag_r <= block_done_flag_nxt;
      end
   end

   // read data valid only in the cycle after the strobe
   always_comb
   begin
      rdata_nxt = RD_ZERO;
      if (i_rd)
      begin
         case (i_addr)
            OFS_SRC_START: rdata_nxt = src_start_addr_r;
            OFS_DST_START: rdata_nxt = dst_start_addr_r;
            OFS_SRC_SIZE:  rdata_nxt = {UPPER_ZERO, src_byte_count_r};
            OFS_DST_SIZE:  rdata_nxt = {UPPER_ZERO, dst_byte_count_r};
            OFS_SRC_PTR:   rdata_nxt = {UPPER_ZERO, src_byte_index_r};
            default:       rdata_nxt = RD_ZERO;
         endcase
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         rdata_r <= RD_ZERO;
      end
      else
      begin
         rdata_r <= rdata_nxt;
      end
   end

   assign o_rdata           = rdata_r;
   assign o_src_start_addr  = src_start_addr_r;
   assign o_dst_start_addr  = dst_start_addr_r;
   assign o_src_byte_count  = src_byte_count_r;
   assign o_dst_byte_count  = dst_byte_count_r;
   assign o_src_byte_index  = src_byte_index_r;
   assign o_block_done_flag = block_done_flag_r;

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);

   sequence seq_wr(logic [ADDR_W-1:0] a);
      i_wr && (i_addr == a);
   endsequence

   sequence seq_rd(logic [ADDR_W-1:0] a);
      i_rd && (i_addr == a);
   endsequence

   sequence seq_quiet_ptr;
      !i_src_step && !pattern_hit && !block_hit;
   endsequence

   sequence seq_ptr_step;
      i_src_step && !pattern_hit && !block_hit;
   endsequence

   sequence seq_cnt_step;
      i_xfer_byte && !pattern_hit && !block_hit;
   endsequence

   chk_src_start_wr: assert property (
      seq_wr(OFS_SRC_START) ##1 seq_rd(OFS_SRC_START)
      |=> o_rdata == $past(i_wdata, 2))
      else $error("source start readback differs from written value");

   chk_dst_start_wr: assert property (
      seq_wr(OFS_DST_START) |=> o_dst_start_addr == $past(i_wdata))
      else $error("destination start not updated by write");

   chk_src_size_wr: assert property (
      seq_wr(OFS_SRC_SIZE) |=> o_src_byte_count == $past(i_wdata[CNT_MSB:CNT_LSB]))
      else $error("source size not updated by write");

   chk_size_upper_zero: assert property (
      (seq_rd(OFS_SRC_SIZE) or seq_rd(OFS_DST_SIZE)) |=> o_rdata[31:16] == UPPER_ZERO)
      else $error("size register upper half not zero");

   chk_dst_size_rd: assert property (
      seq_rd(OFS_DST_SIZE) |=> o_rdata[CNT_MSB:CNT_LSB] == $past(o_dst_byte_count))
      else $error("destination size readback wrong");

   chk_ptr_pattern_clr: assert property (
      pattern_hit |=> o_src_byte_index == RST_SRC_PTR)
      else $error("source index not cleared on pattern");

   chk_ptr_read_only: assert property (
      (seq_wr(OFS_SRC_PTR) and seq_quiet_ptr) |=> $stable(o_src_byte_index))
      else $error("source index changed by a software write");

   chk_done_at_max: assert property (
      (i_xfer_byte && max_count != RST_XFER_CNT
       && (xfer_cnt_r + CNT_ONE) == max_count) |=> o_block_done_flag ##0 xfer_cnt_r == RST_XFER_CNT)
      else $error("block completion missed at larger count");

   chk_done_early: assert property (
      ($rose(o_block_done_flag)) |-> $past(block_hit || pattern_hit))
      else $error("completion flag raised without cause");

   chk_reset_clear: assert property (
      disable iff (1'b0) i_rst |=> (o_dst_start_addr == RST_DST_START)
      && (o_src_byte_count == RST_SRC_SIZE) && !o_block_done_flag)
      else $error("registers not cleared by reset");

   chk_src_start_keep: assert property (
      (!i_wr || i_addr != OFS_SRC_START) |=> $stable(o_src_start_addr))
      else $error("source start changed without a write");

   chk_src_start_rd: assert property (
      seq_rd(OFS_SRC_START) |=> o_rdata == $past(o_src_start_addr))
      else $error("source start readback wrong");

   chk_dst_start_keep: assert property (
      (!i_wr || i_addr != OFS_DST_START) |=> $stable(o_dst_start_addr))
      else $error("destination start changed without a write");

   chk_src_size_rd: assert property (
      seq_rd(OFS_SRC_SIZE) |=> o_rdata[CNT_MSB:CNT_LSB] == $past(o_src_byte_count))
      else $error("source size readback wrong");

   chk_dst_size_wr: assert property (
      seq_wr(OFS_DST_SIZE) |=> o_dst_byte_count == $past(i_wdata[CNT_MSB:CNT_LSB]))
      else $error("destination size not updated by write");

   chk_ptr_rd: assert property (
      seq_rd(OFS_SRC_PTR) |=> o_rdata == {UPPER_ZERO, $past(o_src_byte_index)})
      else $error("source index readback wrong");

   chk_ptr_step: assert property (
      seq_ptr_step |=> o_src_byte_index == $past(o_src_byte_index) + CNT_ONE)
      else $error("source index did not advance");

   chk_xfer_count: assert property (
      seq_cnt_step |=> xfer_cnt_r == $past(xfer_cnt_r) + CNT_ONE)
      else $error("transfer count did not advance");

   chk_done_sticky: assert property (
      (o_block_done_flag && !i_done_clr) |=> o_block_done_flag)
      else $error("completion flag dropped without a clear");

   chk_done_clear: assert property (
      (i_done_clr && !block_hit && !pattern_hit) |=> !o_block_done_flag)
      else $error("completion flag not cleared");

   chk_rdata_idle: assert property (
      !i_rd |=> o_rdata == RD_ZERO)
      else $error("read data not zero outside a read");

endmodule : dcar_regs

// file: dcar_pkg.sv
/*
 * dcar_pkg: constants shared by the per-channel DMA address and size registers.
 * Assumes a byte-addressed register port whose offsets are given here.
 */
package dcar_pkg;

   localparam int ADDR_W  = 8;
   localparam int DATA_W  = 32;
   localparam int CNT_W   = 16;

   // register byte addresses
   localparam logic [ADDR_W-1:0] OFS_SRC_START = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_DST_START = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_SRC_SIZE  = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_DST_SIZE  = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_SRC_PTR   = 8'h10;

   // field positions of the 16-bit size and pointer fields
   localparam int CNT_LSB = 0;
   localparam int CNT_MSB = 15;

   // values after reset, plus the read-data zero, increment and zero-fill constants
   localparam logic [DATA_W-1:0] RST_SRC_START = 32'h0000_0000;
   localparam logic [DATA_W-1:0] RST_DST_START = 32'h0000_0000;
   localparam logic [CNT_W-1:0]  RST_SRC_SIZE  = 16'h0000;
   localparam logic [CNT_W-1:0]  RST_DST_SIZE  = 16'h0000;
   localparam logic [CNT_W-1:0]  RST_SRC_PTR   = 16'h0000;
   localparam logic [CNT_W-1:0]  RST_XFER_CNT  = 16'h0000;
   localparam logic [DATA_W-1:0] RD_ZERO       = 32'h0000_0000;
   localparam logic [CNT_W-1:0]  CNT_ONE       = 16'h0001;
   localparam logic [15:0]       UPPER_ZERO    = 16'h0000;

endpackage : dcar_pkg

// file: dcar_regs_test.sv
/*
 * dcar_regs_test: self-checking bench for the channel address and size registers.
 * Assumes the dcar_pkg offsets and a 10 MHz clock with synchronous reset.
 */
`timescale 1ns/100ps

module dcar_regs_test
   import dcar_pkg::*;
;
   logic              i_clk = 1'b0;
   logic              i_rst = 1'b1;
   logic [ADDR_W-1:0] i_addr = 8'h00;
   logic [DATA_W-1:0] i_wdata = 32'h0000_0000;
   logic              i_wr = 1'b0;
   logic              i_rd = 1'b0;
   logic [DATA_W-1:0] o_rdata;
   logic              i_src_step = 1'b0;
   logic              i_xfer_byte = 1'b0;
   logic              i_pattern_mode = 1'b0;
   logic              i_pattern_det = 1'b0;
   logic              i_done_clr = 1'b0;
   logic [DATA_W-1:0] o_src_start_addr;
   logic [DATA_W-1:0] o_dst_start_addr;
   logic [CNT_W-1:0]  o_src_byte_count;
   logic [CNT_W-1:0]  o_dst_byte_count;
   logic [CNT_W-1:0]  o_src_byte_index;
   logic              o_block_done_flag;
   int                error_cnt = 0;
   int                checks = 0;
   int                cycles = 0;

   dcar_regs dut (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
      .i_rd(i_rd), .o_rdata(o_rdata), .i_src_step(i_src_step), .i_xfer_byte(i_xfer_byte),
      .i_pattern_mode(i_pattern_mode), .i_pattern_det(i_pattern_det), .i_done_clr(i_done_clr),
      .o_src_start_addr(o_src_start_addr), .o_dst_start_addr(o_dst_start_addr),
      .o_src_byte_count(o_src_byte_count), .o_dst_byte_count(o_dst_byte_count),
      .o_src_byte_index(o_src_byte_index), .o_block_done_flag(o_block_done_flag));

   always #50 i_clk = ~i_clk;

   task automatic test_done;
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : test_done

   // hang guard
   always @(posedge i_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 2000)
      begin
         error_cnt = error_cnt + 1;
         test_done();
      end
   end

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks = checks + 1;
      if (seen !== exp)
      begin
         error_cnt = error_cnt + 1;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
      #1;
   endtask : wr

   // write, then read the same address on the very next cycle
   task automatic wr_rd(input logic [7:0] a, input logic [31:0] wd, output logic [31:0] d);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= wd;
      @(posedge i_clk);
      i_wr <= 1'b0;
      i_rd <= 1'b1;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1 d = o_rdata;
   endtask : wr_rd

   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1 d = o_rdata;
   endtask : rd

   // engine strobes {mode, det, step, xfer, clr} held for n sampled edges
   task automatic eng(input logic [4:0] s, input int n);
      @(posedge i_clk);
      {i_pattern_mode, i_pattern_det, i_src_step, i_xfer_byte, i_done_clr} <= s;
      repeat (n) @(posedge i_clk);
      {i_pattern_mode, i_pattern_det, i_src_step, i_xfer_byte, i_done_clr} <= 5'h00;
      #1;
   endtask : eng

   task automatic t_reset;
      logic [31:0] d;
      rd(OFS_SRC_START, d);
      chk("src start", d, 32'h0000_0000);
      chk("done flag", {31'h0, o_block_done_flag}, 32'h0000_0000);
      rd(OFS_DST_START, d); chk("dst start", d, 32'h0000_0000);
      rd(OFS_SRC_SIZE, d); chk("src size", d, 32'h0000_0000);
      rd(OFS_DST_SIZE, d); chk("dst size", d, 32'h0000_0000);
      rd(OFS_SRC_PTR, d); chk("src index", d, 32'h0000_0000);
      $display("reset values done");
   endtask : t_reset

   task automatic t_rw;
      logic [31:0] d;
      wr_rd(OFS_SRC_START, 32'hA5C3_0FF1, d);
      chk("src start b2b", d, 32'hA5C3_0FF1);
      @(posedge i_clk);
      #1 chk("rdata idle", o_rdata, RD_ZERO);
      wr(OFS_DST_START, 32'h5A3C_F00E);
      wr(OFS_SRC_SIZE, 32'hFFFF_FFFF);
      wr(OFS_DST_SIZE, 32'h1234_FFFF);
      wr(8'h2C, 32'h0000_0000);
      chk("src start out", o_src_start_addr, 32'hA5C3_0FF1);
      chk("dst start out", o_dst_start_addr, 32'h5A3C_F00E);
      chk("dst count", {UPPER_ZERO, o_dst_byte_count}, 32'h0000_FFFF);
      rd(OFS_SRC_START, d); chk("src start", d, 32'hA5C3_0FF1);
      rd(OFS_DST_START, d); chk("dst start", d, 32'h5A3C_F00E);
      rd(OFS_SRC_SIZE, d); chk("src size", d, 32'h0000_FFFF);
      chk("src count", {UPPER_ZERO, o_src_byte_count}, 32'h0000_FFFF);
      rd(OFS_DST_SIZE, d); chk("dst size", d, 32'h0000_FFFF);
      rd(8'h2C, d);
      chk("unmapped", d, 32'h0000_0000);
      $display("read write done");
   endtask : t_rw

   task automatic t_ptr;
      logic [31:0] d;
      eng(5'h04, 3);
      wr(OFS_SRC_PTR, 32'h0000_FFFF);
      rd(OFS_SRC_PTR, d);
      chk("index ro", d, 32'h0000_0003);
      eng(5'h08, 1);
      chk("index no mode", {UPPER_ZERO, o_src_byte_index}, 32'h0000_0003);
      eng(5'h18, 1);
      chk("index cleared", {UPPER_ZERO, o_src_byte_index}, 32'h0000_0000);
      chk("pattern done", {31'h0, o_block_done_flag}, 32'h0000_0001);
      eng(5'h01, 1);
      chk("flag clear", {31'h0, o_block_done_flag}, 32'h0000_0000);
      $display("source index done");
   endtask : t_ptr

   task automatic t_done;
      wr(OFS_SRC_SIZE, 32'h0000_0002);
      wr(OFS_DST_SIZE, 32'h0000_0003);
      eng(5'h04, 1);
      eng(5'h02, 2);
      chk("early flag", {31'h0, o_block_done_flag}, 32'h0000_0000);
      // last byte meets a clear: the set must win
      eng(5'h03, 1);
      chk("done flag", {31'h0, o_block_done_flag}, 32'h0000_0001);
      chk("index reset", {UPPER_ZERO, o_src_byte_index}, 32'h0000_0000);
      eng(5'h01, 1);
      chk("flag clear", {31'h0, o_block_done_flag}, 32'h0000_0000);
      $display("block completion done");
   endtask : t_done

   // reset in mid-run with the start address and size registers holding non-zero values
   task automatic t_rst;
      @(posedge i_clk);
      i_rst <= 1'b1;
      @(posedge i_clk);
      i_rst <= 1'b0;
      #1;
      chk("src start rst", o_src_start_addr, RST_SRC_START);
      chk("dst start rst", o_dst_start_addr, RST_DST_START);
      chk("src size rst", {UPPER_ZERO, o_src_byte_count}, 32'h0000_0000);
      chk("dst size rst", {UPPER_ZERO, o_dst_byte_count}, 32'h0000_0000);
      $display("mid-run reset done");
   endtask : t_rst

   initial
   begin
      repeat (4) @(posedge i_clk);
      i_rst <= 1'b0;
      t_reset();
      t_rw();
      t_ptr();
      t_done();
      t_rst();
      test_done();
   end

endmodule : dcar_regs_test
